// *** memory_space_decode.sv ***
// Memory space map, page register and decode top level
// What this block does
// - Map value 0Ch: fetches reach primary flash, reads the rest.
// - Map bits 2 and 4 both set put primary flash in combined space.
// - Map bits: 7 peripheral mode, 4..0 strobe-to-memory grants.
// - Eight-bit page register, writable and readable by the processor.
// - Page register sits at offset E0h of the register space.
// - All page bits are inputs to the decode array terms.
// - Page bits also feed the general logic array.
// - Fast bit clear: arrays enter standby after about 70 ns idle.
// - Five power register 2 bits block control signals from arrays.
// - Array input bus carries the listed 73 signals.
// - Wide-address mode feeds address bits 19..4 to the arrays.
// - Eight primary sector selects, three product terms each.
// - Four secondary sector selects, three product terms each.
// - One SRAM select from up to two product terms.
// - Register space, test port and two peripheral selects.
// - Three external chip selects without using output macrocells.
// - Sixteen output, 24 input macrocells, 137 product terms.
// - Processor loads output macrocells and reads both kinds back.
// - Programmed logic works from reset with no processor action.
// - Map register starts configured and software may rewrite it.
// - Secondary flash wins where its select overlaps a primary one.
`timescale 1ns/100ps
`include "memory_space_defines.svh"
module memory_space_decode
  import memory_space_pkg::*;
#(
  parameter dterm_t DECODE_TERMS [`DT_N] = DEFAULT_DTERMS,
  parameter gterm_t LOGIC_TERMS [`PT_CAP] = '{default: '0},
  parameter logic [7:0] MAP_INIT = `MAP_RESET
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [19:0] address,
  input wire logic program_fetch_strobe_n,
  input wire logic control_line_one_n,
  input wire logic write_strobe_n,
  input wire logic addr_latch,
  input wire logic byte_high_n,
  input wire logic wide_address_mode,
  input wire logic system_reset,
  input wire logic power_down_input,
  input wire logic [7:0] data_in,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_c_in,
  input wire logic [2:0] port_d_in,
  input wire logic secondary_ready,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic [7:0] primary_sector_selects,
  output logic [3:0] secondary_sector_selects,
  output logic sram_select,
  output logic config_select,
  output logic test_port_select,
  output logic [1:0] periph_selects,
  output logic [2:0] external_chip_selects,
  output logic [15:0] macrocell_out,
  output logic standby
);
  pld_bus_if bus ();

  logic [7:0] page_q;
  logic [7:0] page_d;
  logic [7:0] map_q;
  logic [7:0] map_d;
  logic [7:0] pmm0_q;
  logic [7:0] pmm0_d;
  logic [7:0] pmm2_q;
  logic [7:0] pmm2_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rd_oe_q;
  logic rd_oe_d;
  logic fetch_raw;
  logic rd_raw;
  logic wr_raw;
  logic [7:0] cfg_off;
  logic cfg_hit;
  logic cfg_wr;
  logic cfg_rd;
  logic [7:0] pri_c;
  logic [3:0] sec_c;
  logic sram_c;
  logic test_c;
  logic [1:0] per_c;
  logic [2:0] ecs_c;
  logic [15:0] ocell_q;
  logic [23:0] icell_q;
  logic standby_c;
  logic [7:0] pri_q;
  logic [3:0] sec_q;
  logic sram_q;
  logic cfg_q;
  logic test_q;
  logic [1:0] per_q;
  logic [2:0] ecs_q;

  // Strobes are active low at the pins
  assign fetch_raw = ~program_fetch_strobe_n;
  assign rd_raw = ~control_line_one_n;
  assign wr_raw = ~write_strobe_n;

  // Array inputs; blocked strobes read as idle inside both arrays
  assign bus.addr = wide_address_mode ? address[19:4] :
                                        address[15:0];
  assign bus.page = page_q;
  assign bus.wr = wr_raw & ~pmm2_q[`BLK_WR];
  assign bus.rd = rd_raw & ~pmm2_q[`BLK_RD];
  assign bus.fetch = fetch_raw & ~pmm2_q[`BLK_FE];
  assign bus.ale = addr_latch & ~pmm2_q[`BLK_ALE];
  assign bus.bhe = ~byte_high_n & ~pmm2_q[`BLK_BHE];
  assign bus.rst = system_reset;
  assign bus.pwr_down = power_down_input;

  decode_array #(
    .TERMS(DECODE_TERMS)
  ) u_decode (
    .bus(bus),
    .map(map_q),
    .primary_sector_selects(pri_c),
    .secondary_sector_selects(sec_c),
    .sram_select(sram_c),
    .config_select(cfg_hit),
    .test_port_select(test_c),
    .periph_selects(per_c)
  );

  general_logic_array #(
    .TERMS(LOGIC_TERMS)
  ) u_logic (
    .clock(clock),
    .nrst(nrst),
    .bus(bus),
    .fast_mode(pmm0_q[`FAST_BIT]),
    .port_a_in(port_a_in),
    .port_b_in(port_b_in),
    .port_c_in(port_c_in),
    .port_d_in(port_d_in),
    .secondary_ready(secondary_ready),
    .ocell_ab_we(cfg_wr && cfg_off == `OCELL_AB_OFF),
    .ocell_bc_we(cfg_wr && cfg_off == `OCELL_BC_OFF),
    .wdata(data_in),
    .ocell_q(ocell_q),
    .icell_q(icell_q),
    .external_chip_selects(ecs_c),
    .standby_q(standby_c)
  );

  // Register space access uses the raw strobes so blocking bits
  // never lock software out of the registers that clear them
  assign cfg_off = address[7:0];
  assign cfg_wr = cfg_hit & wr_raw;
  assign cfg_rd = cfg_hit & rd_raw;

  // Register writes; unused map and power register 2 bits are stored as zero
  always_comb begin
    page_d = page_q;
    map_d = map_q;
    pmm0_d = pmm0_q;
    pmm2_d = pmm2_q;
    if (cfg_wr) begin
      unique case (cfg_off)
        `PAGE_OFF: page_d = data_in;
        `MAP_OFF: map_d = data_in & `MAP_USED;
        `PMM0_OFF: pmm0_d = data_in;
        `PMM2_OFF: pmm2_d = data_in & `PMM2_USED;
        default: ;
      endcase
    end
  end

  // Read-back mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    rd_oe_d = cfg_rd;
    if (cfg_rd) begin
      unique case (cfg_off)
        `PAGE_OFF: rdata_d = page_q;
        `MAP_OFF: rdata_d = map_q;
        `PMM0_OFF: rdata_d = pmm0_q;
        `PMM2_OFF: rdata_d = pmm2_q;
        `OCELL_AB_OFF: rdata_d = ocell_q[7:0];
        `OCELL_BC_OFF: rdata_d = ocell_q[15:8];
        `ICELL_A_OFF: rdata_d = icell_q[7:0];
        `ICELL_B_OFF: rdata_d = icell_q[15:8];
        `ICELL_C_OFF: rdata_d = icell_q[23:16];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Map starts from its configured value, 0Ch splits the spaces
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      page_q <= `PAGE_RESET;
      map_q <= MAP_INIT;
      pmm0_q <= `PMM_RESET;
      pmm2_q <= `PMM_RESET;
      rdata_q <= 8'h00;
      rd_oe_q <= 1'b0;
    end else begin
      page_q <= page_d;
      map_q <= map_d;
      pmm0_q <= pmm0_d;
      pmm2_q <= pmm2_d;
      rdata_q <= rdata_d;
      rd_oe_q <= rd_oe_d;
    end
  end

  // Selects are registered so every output leaves a flip-flop,
  // at the cost of one cycle behind the address
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pri_q <= '0;
      sec_q <= '0;
      sram_q <= 1'b0;
      cfg_q <= 1'b0;
      test_q <= 1'b0;
      per_q <= '0;
      ecs_q <= '0;
    end else begin
      pri_q <= pri_c;
      sec_q <= sec_c;
      sram_q <= sram_c;
      cfg_q <= cfg_hit;
      test_q <= test_c;
      per_q <= per_c;
      ecs_q <= ecs_c;
    end
  end

  assign data_out = rdata_q;
  assign data_oe = rd_oe_q;
  assign primary_sector_selects = pri_q;
  assign secondary_sector_selects = sec_q;
  assign sram_select = sram_q;
  assign config_select = cfg_q;
  assign test_port_select = test_q;
  assign periph_selects = per_q;
  assign external_chip_selects = ecs_q;
  assign macrocell_out = ocell_q;
  assign standby = standby_c;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_page_write;
    cfg_wr && cfg_off == `PAGE_OFF;
  endsequence

  sequence s_page_read;
    cfg_rd && cfg_off == `PAGE_OFF;
  endsequence

  property p_page_write;
    s_page_write ##1 1'b1 |-> page_q == $past(data_in);
  endproperty
  a_page_write: assert property (p_page_write)
    else $error("page register write lost");

  property p_page_read;
    s_page_read ##0 !cfg_wr |=> data_oe && data_out == page_q;
  endproperty
  a_page_read: assert property (p_page_read)
    else $error("page register read wrong");

  property p_map_write;
    cfg_wr && cfg_off == `MAP_OFF |=>
      map_q == ($past(data_in) & `MAP_USED);
  endproperty
  a_map_write: assert property (p_map_write)
    else $error("map register write lost");

  property p_fetch_gate;
    fetch_raw && !rd_raw && !wr_raw && !map_q[`MAP_FE_PRI] |=>
      primary_sector_selects == 8'h00;
  endproperty
  a_fetch_gate: assert property (p_fetch_gate)
    else $error("primary flash answered an ungranted fetch");

  property p_sec_priority;
    |secondary_sector_selects |-> primary_sector_selects == 8'h00;
  endproperty
  a_sec_priority: assert property (p_sec_priority)
    else $error("primary and secondary selected together");

  property p_wide_addr;
    wide_address_mode |-> bus.addr == address[19:4];
  endproperty
  a_wide_addr: assert property (p_wide_addr)
    else $error("wide mode address not shifted");

  property p_block_read;
    pmm2_q[`BLK_RD] |-> !bus.rd;
  endproperty
  a_block_read: assert property (p_block_read)
    else $error("blocked read strobe reached arrays");

  property p_page_to_arrays;
    s_page_write |=> bus.page == $past(data_in);
  endproperty
  a_page_to_arrays: assert property (p_page_to_arrays)
    else $error("page bits not seen by arrays");
endmodule

// *** memory_space_defines.svh ***
// Offsets, field positions, reset values and timing counts of the block
`ifndef MEMORY_SPACE_DEFINES_SVH
`define MEMORY_SPACE_DEFINES_SVH

// Configuration space window and register offsets within it
`define CFG_BASE 16'hFF00
`define CFG_MASK 16'hFF00
`define PAGE_OFF 8'hE0
`define MAP_OFF 8'hE2
`define PMM0_OFF 8'hB0
`define PMM2_OFF 8'hB4
`define OCELL_AB_OFF 8'h20
`define OCELL_BC_OFF 8'h21
`define ICELL_A_OFF 8'h0A
`define ICELL_B_OFF 8'h0B
`define ICELL_C_OFF 8'h18

// Reset values
`define MAP_RESET 8'h0C
`define PAGE_RESET 8'h00
`define PMM_RESET 8'h00

// Map register fields
`define MAP_PIO 7
`define MAP_RD_PRI 4
`define MAP_RD_SEC 3
`define MAP_FE_PRI 2
`define MAP_FE_SEC 1
`define MAP_FE_SRAM 0
`define MAP_USED 8'h9F

// Power management fields; blocking bits in register 2
`define FAST_BIT 3
`define BLK_WR 0
`define BLK_RD 1
`define BLK_FE 2
`define BLK_ALE 3
`define BLK_BHE 4
`define PMM2_USED 8'h1F

// Array sizes
`define IN_BUS_W 73
`define GT_W 75
`define PT_CAP 137
`define DT_N 42

// Standby entry: least idle time, rounded up to clock cycles
`define STANDBY_NS 70
`define CLOCK_NS 10
`define STANDBY_CYCLES ((`STANDBY_NS + `CLOCK_NS - 1) / `CLOCK_NS)

`endif

// *** memory_space_pkg.sv ***
// Types, term tables and term match functions shared by the decode logic
package memory_space_pkg;
`include "memory_space_defines.svh"

  typedef struct packed {
    logic used;
    logic [23:0] mask;
    logic [23:0] value;
  } dterm_t;

  typedef struct packed {
    logic used;
    logic [`GT_W-1:0] mask;
    logic [`GT_W-1:0] value;
  } gterm_t;

  typedef enum logic {PWR_ACTIVE, PWR_STANDBY} power_state_t;

  // Only the configuration window is mapped until the user loads a table
  localparam dterm_t DEFAULT_DTERMS [`DT_N] = '{
    38: '{1'b1, {8'h00, `CFG_MASK}, {8'h00, `CFG_BASE}},
    default: '0
  };

  // Product term over page and address
  function automatic logic dterm_hit(dterm_t t, logic [23:0] in);
    return t.used && ((in & t.mask) == (t.value & t.mask));
  endfunction

  // Product term over the general array input bus
  function automatic logic gterm_hit(gterm_t t, logic [`GT_W-1:0] in);
    return t.used && ((in & t.mask) == (t.value & t.mask));
  endfunction
endpackage

// *** pld_bus_if.sv ***
// Array input signals shared by the decode and general logic arrays
`timescale 1ns/100ps
interface pld_bus_if;
  logic [15:0] addr;
  logic [7:0] page;
  logic fetch;
  logic rd;
  logic wr;
  logic ale;
  logic bhe;
  logic rst;
  logic pwr_down;
  modport src (output addr, page, fetch, rd, wr, ale, bhe, rst, pwr_down);
  modport sink (input addr, page, fetch, rd, wr, ale, bhe, rst, pwr_down);
endinterface

// *** decode_array.sv ***
// Address decode: sector, memory, register space and peripheral selects
`timescale 1ns/100ps
`include "memory_space_defines.svh"
module decode_array
  import memory_space_pkg::*;
#(
  parameter dterm_t TERMS [`DT_N] = DEFAULT_DTERMS
) (
  pld_bus_if.sink bus,
  input wire logic [7:0] map,
  output logic [7:0] primary_sector_selects,
  output logic [3:0] secondary_sector_selects,
  output logic sram_select,
  output logic config_select,
  output logic test_port_select,
  output logic [1:0] periph_selects
);
  logic [23:0] term_in;
  logic [7:0] pri_hit;
  logic [3:0] sec_hit;
  logic sram_hit;
  logic [1:0] per_hit;
  logic io_hit;
  logic pri_ok;
  logic sec_ok;
  logic sram_ok;

  assign term_in = {bus.page, bus.addr};

  // Raw address hits, each select an OR of its own product terms
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pri_hit[i] = dterm_hit(TERMS[3*i], term_in) |
                   dterm_hit(TERMS[3*i+1], term_in) |
                   dterm_hit(TERMS[3*i+2], term_in);
    end
    for (int j = 0; j < 4; j++) begin
      sec_hit[j] = dterm_hit(TERMS[24+3*j], term_in) |
                   dterm_hit(TERMS[25+3*j], term_in) |
                   dterm_hit(TERMS[26+3*j], term_in);
    end
    sram_hit = dterm_hit(TERMS[36], term_in) |
               dterm_hit(TERMS[37], term_in);
    per_hit[0] = dterm_hit(TERMS[40], term_in);
    per_hit[1] = dterm_hit(TERMS[41], term_in);
  end

  // Strobe permissions from the map register; both fetch and read bits
  // set put the primary flash in combined space
  assign pri_ok = (bus.fetch & map[`MAP_FE_PRI]) |
                  (bus.rd & map[`MAP_RD_PRI]) | bus.wr;
  assign sec_ok = (bus.fetch & map[`MAP_FE_SEC]) |
                  (bus.rd & map[`MAP_RD_SEC]) | bus.wr;
  assign sram_ok = (bus.fetch & map[`MAP_FE_SRAM]) | bus.rd | bus.wr;

  // SRAM and register spaces beat flash; secondary beats primary
  assign io_hit = sram_hit | config_select | (|periph_selects);
  assign config_select = dterm_hit(TERMS[38], term_in);
  assign test_port_select = dterm_hit(TERMS[39], term_in);
  assign periph_selects = per_hit & {2{map[`MAP_PIO] & (bus.rd | bus.wr)}};
  assign sram_select = sram_hit & sram_ok;
  assign secondary_sector_selects = sec_hit & {4{~io_hit & sec_ok}};
  assign primary_sector_selects =
    pri_hit & {8{~io_hit & ~(|sec_hit) & pri_ok}};
endmodule

// *** general_logic_array.sv ***
// General logic array: input bus, macrocells, chip selects and standby
`timescale 1ns/100ps
`include "memory_space_defines.svh"
module general_logic_array
  import memory_space_pkg::*;
#(
  parameter gterm_t TERMS [`PT_CAP] = '{default: '0}
) (
  input wire logic clock,
  input wire logic nrst,
  pld_bus_if.sink bus,
  input wire logic fast_mode,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_c_in,
  input wire logic [2:0] port_d_in,
  input wire logic secondary_ready,
  input wire logic ocell_ab_we,
  input wire logic ocell_bc_we,
  input wire logic [7:0] wdata,
  output logic [15:0] ocell_q,
  output logic [23:0] icell_q,
  output logic [2:0] external_chip_selects,
  output logic standby_q
);
  localparam int unsigned IDLE_N = `STANDBY_CYCLES;
  logic [`IN_BUS_W-1:0] in_bus;
  logic [`GT_W-1:0] term_in;
  logic [`PT_CAP-1:0] hit;
  logic [15:0] ocell_d;
  logic [23:0] icell_d;
  logic [`IN_BUS_W-1:0] prev_q;
  logic [3:0] idle_q;
  logic [3:0] idle_d;
  power_state_t pstate_q;
  power_state_t pstate_d;

  // 73-wide input bus: address, controls, reset, power-down, inputs
  assign in_bus = {secondary_ready, ocell_q, bus.page, port_d_in,
                   icell_q, bus.pwr_down, bus.rst, bus.fetch, bus.rd, bus.wr,
                   bus.addr};
  assign term_in = {bus.bhe, bus.ale, in_bus};

  // Full product term array; first 128 feed macrocells, last 9 selects
  always_comb begin
    for (int k = 0; k < `PT_CAP; k++) begin
      hit[k] = gterm_hit(TERMS[k], term_in);
    end
    for (int j = 0; j < 3; j++) begin
      external_chip_selects[j] = |hit[128+3*j +: 3];
    end
  end

  // Processor load beats the array; input cells pass the pins through
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      ocell_d[i] = |hit[8*i +: 8];
    end
    if (ocell_ab_we) begin
      ocell_d[7:0] = wdata;
    end
    if (ocell_bc_we) begin
      ocell_d[15:8] = wdata;
    end
    icell_d = {port_c_in, port_b_in, port_a_in};
  end

  // Reset clears macrocells; the term table itself needs no loading
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ocell_q <= '0;
      icell_q <= '0;
    end else begin
      ocell_q <= ocell_d;
      icell_q <= icell_d;
    end
  end

  // Idle counter; only a status, propagation slowdown is not modelled
  always_comb begin
    idle_d = idle_q;
    pstate_d = pstate_q;
    if (fast_mode || in_bus != prev_q) begin
      idle_d = '0;
      pstate_d = PWR_ACTIVE;
    end else if (idle_q < 4'(IDLE_N)) begin
      idle_d = idle_q + 4'd1;
    end else begin
      pstate_d = PWR_STANDBY;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prev_q <= '0;
      idle_q <= '0;
      pstate_q <= PWR_ACTIVE;
    end else begin
      prev_q <= in_bus;
      idle_q <= idle_d;
      pstate_q <= pstate_d;
    end
  end
  assign standby_q = (pstate_q == PWR_STANDBY);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_idle_full;
    !fast_mode && idle_q == 4'(IDLE_N) && in_bus == prev_q;
  endsequence

  property p_standby_enter;
    s_idle_full |=> standby_q;
  endproperty
  a_standby_enter: assert property (p_standby_enter)
    else $error("standby not entered after idle time");

  property p_fast_awake;
    fast_mode |=> !standby_q;
  endproperty
  a_fast_awake: assert property (p_fast_awake)
    else $error("standby while fast mode set");

  property p_ocell_load;
    ocell_ab_we |=> ocell_q[7:0] == $past(wdata);
  endproperty
  a_ocell_load: assert property (p_ocell_load)
    else $error("macrocell load lost");
endmodule

// *** mcu_bus_model.sv ***
// Processor bus master model: address, strobes and write data
`timescale 1ns/100ps
module mcu_bus_model (
  input wire logic clock,
  input wire logic [7:0] data_out,
  output logic [19:0] address,
  output logic fetch_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] data_in
);
  // Idle bus at time zero, all strobes high
  initial begin
    address = 20'h00000;
    fetch_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 8'h00;
  end

  // Kind 0 write, 1 read, 2 fetch; held through the answer edge
  task automatic cyc(input int kind, input logic [19:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    address <= a;
    wr_n <= (kind != 0);
    rd_n <= (kind != 1);
    fetch_n <= (kind != 2);
    data_in <= (kind == 0) ? d : ~data_in;
    @(posedge clock);
    #1 q = data_out;
  endtask

  // Released data line shows the inverse, never a stale copy
  task automatic idle();
    @(posedge clock);
    wr_n <= 1'b1;
    rd_n <= 1'b1;
    fetch_n <= 1'b1;
    data_in <= ~data_in;
  endtask
endmodule

// *** tb_memory_space_decode.sv ***
// Self-checking bench for the memory space decode block
`timescale 1ns/100ps
`include "memory_space_defines.svh"
module tb_memory_space_decode;
  import memory_space_pkg::*;
  // Primary 0 below 8000h, primary 1 at C000h on page 01,
  // secondary 0 overlapping at 4000h, SRAM at 8000h
  localparam dterm_t TERMS [`DT_N] = '{
    0: '{1'b1, 24'h008000, 24'h000000},
    3: '{1'b1, 24'hFFC000, 24'h01C000},
    24: '{1'b1, 24'h00C000, 24'h004000},
    36: '{1'b1, 24'h00E000, 24'h008000},
    38: '{1'b1, 24'h00FF00, 24'h00FF00},
    // Test port at A000h, peripheral 0 at B000h
    39: '{1'b1, 24'h00F000, 24'h00A000},
    40: '{1'b1, 24'h00F000, 24'h00B000},
    default: '0
  };
  // External chip select 0 on addresses D000h to DFFFh
  localparam gterm_t LTERMS [`PT_CAP] = '{
    128: '{1'b1, 75'h0F000, 75'h0D000},
    default: '0
  };
  logic clock, nrst, wide, power_down;
  logic test_port_select;
  logic [1:0] periph_selects;
  logic [2:0] external_chip_selects;
  logic [7:0] pa, pb, pc;
  logic [19:0] address;
  logic fetch_n, rd_n, wr_n, data_oe, config_select, standby;
  logic [7:0] data_in, data_out, primary_sector_selects;
  logic [3:0] secondary_sector_selects;
  logic sram_select;
  logic [15:0] macrocell_out;
  int num_errors = 0;
  int n_checks = 0;

  memory_space_decode #(
    .DECODE_TERMS(TERMS), .LOGIC_TERMS(LTERMS)
  ) memory_space_decode_i (
    .clock(clock), .nrst(nrst), .address(address),
    .program_fetch_strobe_n(fetch_n), .control_line_one_n(rd_n),
    .write_strobe_n(wr_n), .addr_latch(1'b0), .byte_high_n(1'b1),
    .wide_address_mode(wide), .system_reset(1'b0),
    .power_down_input(power_down), .data_in(data_in), .port_a_in(pa),
    .port_b_in(pb), .port_c_in(pc), .port_d_in(3'h0),
    .secondary_ready(1'b1), .data_out(data_out), .data_oe(data_oe),
    .primary_sector_selects(primary_sector_selects),
    .secondary_sector_selects(secondary_sector_selects),
    .sram_select(sram_select), .config_select(config_select),
    .test_port_select(test_port_select),
    .periph_selects(periph_selects),
    .external_chip_selects(external_chip_selects),
    .macrocell_out(macrocell_out),
    .standby(standby));

  mcu_bus_model mcu_bus_model_i (
    .clock(clock), .data_out(data_out), .address(address),
    .fetch_n(fetch_n), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in));

  // Free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    logic [7:0] q;
    mcu_bus_model_i.cyc(0, a, d, q);
  endtask

  task automatic rd(input logic [19:0] a, output logic [7:0] q);
    mcu_bus_model_i.cyc(1, a, 8'h00, q);
  endtask

  // Expected {primary, secondary, sram} one edge after the strobe
  task automatic sel(input int k, input logic [19:0] a,
                     input logic [12:0] e);
    logic [7:0] q;
    mcu_bus_model_i.cyc(k, a, 8'h00, q);
    check("selects", {3'h0, e}, {3'h0, primary_sector_selects,
          secondary_sector_selects, sram_select});
  endtask

  task automatic t_reset();
    logic [7:0] q;
    rd(20'h0FFE0, q);
    check("page", 16'h0000, q);
    rd(20'h0FFE2, q);
    check("map", 16'h000C, q);
    $display("t_reset done");
  endtask

  task automatic t_regs();
    logic [7:0] q;
    wr(20'h0FFE0, 8'h55);
    rd(20'h0FFE0, q);
    check("page", 16'h0055, q);
    check("oe", 16'h0001, data_oe);
    check("cfg sel", 16'h0001, config_select);
    wr(20'h0FFE0, 8'hAA);
    rd(20'h0FFE0, q);
    check("page", 16'h00AA, q);
    wr(20'h0FFE2, 8'hFF);
    rd(20'h0FFE2, q);
    check("map", 16'h009F, q);
    wr(20'h0FFB4, 8'hFF);
    rd(20'h0FFB4, q);
    check("pmm2", 16'h001F, q);
    wr(20'h0FFB4, 8'h00);
    rd(20'h0FFE1, q);
    check("unmapped", 16'h0100, {7'h00, data_oe, q});
    rd(20'h01234, q);
    check("outside", 16'h0000, {6'h00, config_select, data_oe, q});
    wr(20'h0FFE2, 8'h0C);
    wr(20'h0FFE0, 8'h00);
    $display("t_regs done");
  endtask

  task automatic t_space();
    sel(2, 20'h00000, 13'h0020);
    sel(1, 20'h00000, 13'h0000);
    sel(1, 20'h04000, 13'h0002);
    sel(2, 20'h04000, 13'h0000);
    sel(1, 20'h08000, 13'h0001);
    sel(2, 20'h08000, 13'h0000);
    wr(20'h0FFE2, 8'h14);
    sel(1, 20'h00000, 13'h0020);
    sel(2, 20'h00000, 13'h0020);
    wr(20'h0FFE2, 8'h0B);
    sel(2, 20'h04000, 13'h0002);
    sel(2, 20'h08000, 13'h0001);
    sel(1, 20'h00000, 13'h0000);
    wr(20'h0FFE2, 8'h0C);
    $display("t_space done");
  endtask

  task automatic t_page();
    wr(20'h0FFE0, 8'h01);
    sel(2, 20'h0C000, 13'h0040);
    wr(20'h0FFE0, 8'h00);
    sel(2, 20'h0C000, 13'h0000);
    @(posedge clock);
    wide <= 1'b1;
    sel(2, 20'h08000, 13'h0020);
    @(posedge clock);
    wide <= 1'b0;
    sel(1, 20'h08000, 13'h0001);
    $display("t_page done");
  endtask

  // Test port, peripheral and external selects; peripheral needs bit 7
  task automatic t_misc();
    sel(1, 20'h0A000, 13'h0000);
    check("test sel", 16'h0001, test_port_select);
    sel(1, 20'h0B000, 13'h0000);
    check("periph", 16'h0000, periph_selects);
    wr(20'h0FFE2, 8'h8C);
    sel(1, 20'h0B000, 13'h0000);
    check("periph", 16'h0001, periph_selects);
    wr(20'h0FFE2, 8'h0C);
    sel(2, 20'h0D000, 13'h0000);
    check("ecs", 16'h0001, external_chip_selects);
    check("test sel", 16'h0000, test_port_select);
    $display("t_misc done");
  endtask

  task automatic t_macro();
    logic [7:0] q;
    wr(20'h0FF20, 8'hA5);
    check("omc ab", 16'h00A5, macrocell_out[7:0]);
    wr(20'h0FF21, 8'h3C);
    check("omc bc", 16'h003C, macrocell_out[15:8]);
    rd(20'h0FF21, q);
    check("ocell bc read", 16'h003C, q);
    @(posedge clock);
    pa <= 8'h5A;
    pb <= 8'hC3;
    pc <= 8'h81;
    rd(20'h0FF0A, q);
    check("imc a", 16'h005A, q);
    rd(20'h0FF0B, q);
    check("imc b", 16'h00C3, q);
    rd(20'h0FF18, q);
    check("imc c", 16'h0081, q);
    $display("t_macro done");
  endtask

  // Idle span must exceed the seven quiet edges before standby
  task automatic t_standby();
    mcu_bus_model_i.idle();
    repeat (10) @(posedge clock);
    #1 check("standby", 16'h0001, standby);
    @(posedge clock);
    power_down <= 1'b1;
    repeat (2) @(posedge clock);
    #1 check("wake", 16'h0000, standby);
    wr(20'h0FFB0, 8'h08);
    mcu_bus_model_i.idle();
    repeat (10) @(posedge clock);
    #1 check("fast", 16'h0000, standby);
    wr(20'h0FFB0, 8'h00);
    $display("t_standby done");
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence after six cycles of reset
  initial begin
    nrst = 1'b0;
    wide = 1'b0;
    power_down = 1'b0;
    pa = 8'h00;
    pb = 8'h00;
    pc = 8'h00;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    t_reset();
    t_regs();
    t_space();
    t_page();
    t_misc();
    t_macro();
    t_standby();
    summarize();
  end

  // Watchdog, far beyond the roughly 130 cycles the tests take
  initial begin
    #100000;
    num_errors++;
    summarize();
  end
endmodule
